/* File: core/ddsc_port.sv */
// Serial command port of a dual 10-bit current DAC: two-wire slave or SPI shift.
// Assumes SCL/SDA/SCLK/DIN/CS are already synchronous to clk_i and slow against it.
// Overview of operation
// RL1: Seven-bit addressing only, no ten-bit format
// RL2: Write only; read address not acknowledged
// RL3: Sample SDA on SCL rise; high-phase changes control
// RL4: Detect START and STOP; STOP releases bus
// RL5: Repeated START begins a new write
// RL6: STOP honoured at any bit position
// RL7: Receiver holds SDA low through ninth clock
// RL8: Master retries after missing acknowledge; the bench master model does not retry
// RL9: Address 01100 plus two strapped pins
// RL10: Master sends direction bit zero to write
// RL11: Acknowledge own address with write bit
// RL12: Idle watches START then own address
// RL13: Write is address, command, data with acks
// RL14: Execute on rising edge of 26th SCL
// RL15: Aborted write leaves registers unchanged
// RL16: SPI shifts DIN on SCLK rise while selected
// RL17: SPI frame sixteen bits, command then code
// RL18: Chip select rise latches word, then ignore
// RL19: Master keeps chip select low whole frame
// RL20: Shutdown stops outputs, port stays active
// RL21: Reset restores every default setting
// RL22: Select pin low two-wire, high SPI
// RL23: Decode six command bits into actions
// RL24: Default external reference, lowest ranges
// RL25: Code is offset binary, MSB first
// RL26: After refusal ignore bus until START
module ddsc_port
	import ddsc_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              spi_select_i,    // High selects SPI
	input  wire logic              scl_i,           // SCL or SCLK
	input  wire logic              sda_i,           // SDA or DIN
	input  wire logic              cs_n_i,          // Chip select, SPI mode
	input  wire logic              addr_strap_low_i,
	input  wire logic              addr_strap_high_i,
	output logic                   sda_oe_n_o,      // Low pulls SDA low
	output logic                   sda_o,
	output ddsc_chan_s             chan_a_o,
	output ddsc_chan_s             chan_b_o,
	output logic                   ref_internal_o,
	output logic                   out_en_a_o,      // Outputs enabled, not shut down
	output logic                   out_en_b_o,
	output logic                   cmd_strobe_o     // Pulse per executed command word
);

	ddsc_i2c_e         state_r;
	logic              scl_q_r;
	logic              sda_q_r;
	logic [4:0]        bit_cnt_r;
	logic [1:0]        byte_idx_r;
	logic [7:0]        shift_r;
	logic [WORD_W-1:0] word_r;
	logic [4:0]        spi_cnt_r;
	logic [WORD_W-1:0] spi_sh_r;
	logic              cs_q_r;
	logic              exec_r;
	logic [WORD_W-1:0] exec_word_r;
	logic              i2c_exec_nxt;
	logic              spi_exec_nxt;

	wire scl_rise = scl_i & ~scl_q_r;
	wire scl_fall = ~scl_i & scl_q_r;
	wire i2c_mode = ~spi_select_i;                         // RL22
	wire start_c  = i2c_mode & scl_i & scl_q_r & sda_q_r & ~sda_i;   // RL3 RL4
	wire stop_c   = i2c_mode & scl_i & scl_q_r & ~sda_q_r & sda_i;   // RL3 RL4
	wire [7:0] own_addr = {ADDR_FIXED, addr_strap_high_i, addr_strap_low_i, 1'b0}; // RL9

	// Merges a received bit into a shift register, MSB first
	function automatic logic [7:0] shift8(input logic [7:0] v, input logic b);
		shift8 = {v[6:0], b};
	endfunction

	// Command field of an executed word
	function automatic logic [CMD_W-1:0] cmd_of(input logic [WORD_W-1:0] w);
		cmd_of = w[WORD_W-1:CODE_W];
	endfunction

	// Code field of an executed word, offset binary, MSB first
	function automatic logic [CODE_W-1:0] code_of(input logic [WORD_W-1:0] w);
		code_of = w[CODE_W-1:0];
	endfunction

	// True when the word selects a supported range for the given channel code
	function automatic logic range_ok(input logic [WORD_W-1:0] w, input logic [2:0] sel);
		range_ok = (w[WORD_W-1:WORD_W-3] == sel) && (w[WORD_W-4:CODE_W] <= RANGE_MAX);
	endfunction

	// Line history for edge and condition detection
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			cs_q_r  <= 1'b1;
		end
		else
		begin
			scl_q_r <= scl_i;
			sda_q_r <= sda_i;
			cs_q_r  <= cs_n_i;
		end
	end

	// Execute point: rising edge of the 26th SCL, i.e. the eighth and last bit (bit 0) of the data byte
	always_comb
	begin
		i2c_exec_nxt = (state_r == DDSC_RECV) && scl_rise && (byte_idx_r == BYTE_DATA)
			&& (bit_cnt_r == I2C_LAST_BIT);                  // RL14
	end

	// Two-wire receive state machine
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !i2c_mode)
		begin
			state_r    <= DDSC_IDLE;
			bit_cnt_r  <= 5'h00;
			byte_idx_r <= BYTE_ADDR;
			shift_r    <= 8'h00;
			word_r     <= '0;
			sda_oe_n_o <= 1'b1;
		end
		else if (start_c)
		begin
			// START or repeated START restarts framing from any state
			state_r    <= DDSC_RECV;                         // RL5 RL12 RL26
			bit_cnt_r  <= 5'h00;
			byte_idx_r <= BYTE_ADDR;
			sda_oe_n_o <= 1'b1;
		end
		else if (stop_c)
		begin
			state_r    <= DDSC_IDLE;                         // RL6 RL15
			sda_oe_n_o <= 1'b1;
		end
		else
		begin
			case (state_r)
				DDSC_RECV:
				begin
					if (scl_rise)
					begin
						shift_r   <= shift8(shift_r, sda_i);   // RL3
						bit_cnt_r <= bit_cnt_r + 5'h01;
					end
					else if (scl_fall && bit_cnt_r == I2C_ACK_BIT)
					begin
						bit_cnt_r <= 5'h00;
						if (byte_idx_r == BYTE_ADDR)
						begin
							// Only a 7-bit write to our address is answered
							if (shift_r == own_addr)           // RL1 RL2 RL11
							begin
								state_r    <= DDSC_ACK;
								sda_oe_n_o <= 1'b0;              // RL7
							end
							else
								state_r <= DDSC_IGNORE;          // RL26
						end
						else
						begin
							if (byte_idx_r == BYTE_CMD)
								word_r[15:8] <= shift_r;         // RL13
							else
								word_r[7:0]  <= shift_r;
							state_r    <= DDSC_ACK;
							sda_oe_n_o <= 1'b0;                // RL7
						end
					end
				end
				DDSC_ACK:
				begin
					// Hold SDA low through the ninth clock high phase
					if (scl_fall)
					begin
						sda_oe_n_o <= 1'b1;
						if (byte_idx_r == BYTE_DATA)
							state_r <= DDSC_IGNORE;            // Extra bytes not answered
						else
						begin
							byte_idx_r <= byte_idx_r + 2'h1;
							bit_cnt_r  <= 5'h00;
							state_r    <= DDSC_RECV;
						end
					end
				end
				DDSC_IDLE,
				DDSC_IGNORE:
				begin
					sda_oe_n_o <= 1'b1;
				end
				default:
				begin
					state_r    <= DDSC_IDLE;
					sda_oe_n_o <= 1'b1;
				end
			endcase
		end
	end

	// After the address or command ack the bit counter is 0 again and RECV resumes; after the data ack IGNORE
	// SPI shift register, enabled only while chip select is low
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !spi_select_i || cs_n_i)
		begin
			if (rst_i || !spi_select_i || (cs_n_i && !cs_q_r))
				spi_cnt_r <= 5'h00;
			if (rst_i)
				spi_sh_r <= '0;
		end
		else if (scl_rise)
		begin
			spi_sh_r  <= {spi_sh_r[WORD_W-2:0], sda_i};    // RL16 RL17
			if (spi_cnt_r != SPI_FRAME_LEN + 5'h01)
				spi_cnt_r <= spi_cnt_r + 5'h01;
		end
	end

	// Latch on chip select rise after at least sixteen clocks
	always_comb
	begin
		spi_exec_nxt = spi_select_i && cs_n_i && !cs_q_r
			&& (spi_cnt_r >= SPI_FRAME_LEN);                 // RL18 RL19
	end

	// Capture of the word to execute, one cycle after the trigger
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			exec_r      <= 1'b0;
			exec_word_r <= '0;
		end
		else
		begin
			exec_r <= i2c_exec_nxt || spi_exec_nxt;
			if (i2c_exec_nxt)
				exec_word_r <= {word_r[15:8], shift8(shift_r, sda_i)};  // RL14
			else if (spi_exec_nxt)
				exec_word_r <= spi_sh_r;                   // RL18
		end
	end

	// Command decode into channel and reference state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			chan_a_o       <= '{CODE_RST, CODE_RST, RANGE_RST, 1'b0};  // RL21 RL24
			chan_b_o       <= '{CODE_RST, CODE_RST, RANGE_RST, 1'b0};
			ref_internal_o <= 1'b0;                          // RL24
			cmd_strobe_o   <= 1'b0;
		end
		else
		begin
			cmd_strobe_o <= exec_r;
			if (exec_r)
			begin
				// Code bits kept as offset binary, passed straight to the array
				case (cmd_of(exec_word_r))                   // RL23 RL25
					CMD_LD_AB:
					begin
						chan_a_o.input_code <= code_of(exec_word_r);
						chan_a_o.dac_code   <= code_of(exec_word_r);
						chan_b_o.input_code <= code_of(exec_word_r);
						chan_b_o.dac_code   <= code_of(exec_word_r);
					end
					CMD_LD_A:
					begin
						chan_a_o.input_code <= code_of(exec_word_r);
						chan_a_o.dac_code   <= code_of(exec_word_r);
					end
					CMD_LD_B:
					begin
						chan_b_o.input_code <= code_of(exec_word_r);
						chan_b_o.dac_code   <= code_of(exec_word_r);
					end
					CMD_IN_AB:
					begin
						chan_a_o.input_code <= code_of(exec_word_r);
						chan_b_o.input_code <= code_of(exec_word_r);
					end
					CMD_IN_A:   chan_a_o.input_code <= code_of(exec_word_r);
					CMD_IN_B:   chan_b_o.input_code <= code_of(exec_word_r);
					CMD_UPD_AB:
					begin
						chan_a_o.dac_code <= chan_a_o.input_code;
						chan_b_o.dac_code <= chan_b_o.input_code;
					end
					CMD_UPD_A:   chan_a_o.dac_code <= chan_a_o.input_code;
					CMD_UPD_B:   chan_b_o.dac_code <= chan_b_o.input_code;
					CMD_REF_INT: ref_internal_o <= 1'b1;
					CMD_REF_EXT: ref_internal_o <= 1'b0;
					CMD_SD_AB:
					begin
						chan_a_o.shutdown <= 1'b1;               // RL20
						chan_b_o.shutdown <= 1'b1;
					end
					CMD_SD_A:    chan_a_o.shutdown <= 1'b1;
					CMD_SD_B:    chan_b_o.shutdown <= 1'b1;
					CMD_PU_AB:
					begin
						chan_a_o.shutdown <= 1'b0;
						chan_b_o.shutdown <= 1'b0;
					end
					CMD_PU_A:    chan_a_o.shutdown <= 1'b0;
					CMD_PU_B:    chan_b_o.shutdown <= 1'b0;
					default:
					begin
						// Range commands; unlisted codes act as no-op
						if (range_ok(exec_word_r, CMD_RNG_A))
							chan_a_o.range <= exec_word_r[WORD_W-4:CODE_W];
						else if (range_ok(exec_word_r, CMD_RNG_B))
							chan_b_o.range <= exec_word_r[WORD_W-4:CODE_W];
					end
				endcase
			end
		end
	end

	// Output enables follow shutdown; the serial port never stops
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			out_en_a_o <= 1'b1;
			out_en_b_o <= 1'b1;
			sda_o      <= 1'b0;
		end
		else
		begin
			out_en_a_o <= ~chan_a_o.shutdown;                // RL20
			out_en_b_o <= ~chan_b_o.shutdown;
			sda_o      <= 1'b0;                              // Open drain drives low only
		end
	end

endmodule // ddsc_port

/* File: core/ddsc_pkg.sv */
// Package for the dual DAC serial command port: constants, commands, carriers.
// Assumes a single 50 MHz system clock; serial pins sampled as synchronous inputs.
package ddsc_pkg;
	localparam int         CLK_HZ        = 50_000_000;
	localparam logic [4:0] ADDR_FIXED    = 5'h0c;   // Fixed upper address bits 01100
	localparam int         CODE_W        = 10;
	localparam int         CMD_W         = 6;
	localparam int         WORD_W        = 16;
	localparam logic [4:0] I2C_LAST_BIT  = 5'h07;   // Bit index of last data bit in a byte
	localparam logic [4:0] I2C_ACK_BIT   = 5'h08;   // Ninth clock of a byte
	localparam logic [4:0] SPI_FRAME_LEN = 5'h10;   // Sixteen clocks per frame
	localparam logic [1:0] BYTE_ADDR     = 2'h0;
	localparam logic [1:0] BYTE_CMD      = 2'h1;
	localparam logic [1:0] BYTE_DATA     = 2'h2;
	localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
	localparam logic [2:0] RANGE_RST     = 3'h0;    // Lowest full-scale range
	localparam logic [2:0] RANGE_MAX     = 3'h5;

	// Command codes
	localparam logic [5:0] CMD_NOP      = 6'h00;
	localparam logic [5:0] CMD_LD_AB    = 6'h01;
	localparam logic [5:0] CMD_LD_A     = 6'h02;
	localparam logic [5:0] CMD_LD_B     = 6'h03;
	localparam logic [5:0] CMD_IN_AB    = 6'h04;
	localparam logic [5:0] CMD_IN_A     = 6'h05;
	localparam logic [5:0] CMD_IN_B     = 6'h06;
	localparam logic [5:0] CMD_UPD_AB   = 6'h07;
	localparam logic [5:0] CMD_UPD_A    = 6'h09;
	localparam logic [5:0] CMD_UPD_B    = 6'h0a;
	localparam logic [5:0] CMD_REF_INT  = 6'h0b;
	localparam logic [5:0] CMD_REF_EXT  = 6'h0c;
	localparam logic [5:0] CMD_SD_AB    = 6'h0d;
	localparam logic [5:0] CMD_SD_A     = 6'h0e;
	localparam logic [5:0] CMD_SD_B     = 6'h0f;
	localparam logic [5:0] CMD_PU_AB    = 6'h2d;
	localparam logic [5:0] CMD_PU_A     = 6'h2e;
	localparam logic [5:0] CMD_PU_B     = 6'h2f;
	localparam logic [2:0] CMD_RNG_A    = 3'h2;    // Upper three bits 010
	localparam logic [2:0] CMD_RNG_B    = 3'h6;    // Upper three bits 110

	// State of one DAC channel as seen by the analog side
	typedef struct packed {
		logic [CODE_W-1:0] input_code;
		logic [CODE_W-1:0] dac_code;
		logic [2:0]        range;
		logic              shutdown;
	} ddsc_chan_s;

	typedef enum logic [2:0] {
		DDSC_IDLE,
		DDSC_RECV,
		DDSC_ACK,
		DDSC_IGNORE
	} ddsc_i2c_e;
endpackage

/* File: sim/ddsc_port_asserts.sv */
// Checker for the dual DAC serial command port, bound to ddsc_port.
// Assumes every register runs on clk_i with rst_i synchronous, active high.
module ddsc_port_asserts
	import ddsc_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       spi_select_i,
	input wire logic       scl_i,
	input wire logic       cs_n_i,
	input wire logic       sda_oe_n_o,
	input wire logic       sda_o,
	input wire ddsc_chan_s chan_a_o,
	input wire ddsc_chan_s chan_b_o,
	input wire logic       ref_internal_o,
	input wire logic       out_en_a_o,
	input wire logic       out_en_b_o,
	input wire logic       cmd_strobe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Reset state, outputs and holds of the port
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> sda_oe_n_o && !cmd_strobe_o)
		else $error("ack or strobe active after reset");
	a_sda_drive_low: assert property (sda_o == 1'b0)
		else $error("driven SDA value not low");
	a_ack_held_high: assert property (!spi_select_i && !sda_oe_n_o && scl_i |=> !sda_oe_n_o || !scl_i)
		else $error("ack released while SCL high");
	a_spi_no_ack: assert property (spi_select_i [*4] |-> sda_oe_n_o)
		else $error("SDA pulled in SPI mode");
	a_out_en_a: assert property (out_en_a_o == !$past(chan_a_o.shutdown))
		else $error("channel A enable wrong");
	a_out_en_b: assert property (out_en_b_o == !$past(chan_b_o.shutdown))
		else $error("channel B enable wrong");
	a_strobe_pulse: assert property (cmd_strobe_o |=> !cmd_strobe_o)
		else $error("strobe longer than one cycle");
	a_change_strobed: assert property
		($changed(chan_a_o) || $changed(chan_b_o) || $changed(ref_internal_o) |-> cmd_strobe_o)
		else $error("settings changed without a command");
	a_cs_high_idle: assert property ((spi_select_i && cs_n_i) [*5] |-> !cmd_strobe_o)
		else $error("command while chip select high");
	// Main scenarios
	c_i2c_cmd: cover property (cmd_strobe_o && !spi_select_i);
	c_spi_cmd: cover property (cmd_strobe_o && spi_select_i);
	c_ack: cover property ($fell(sda_oe_n_o));
endmodule // ddsc_port_asserts

bind ddsc_port ddsc_port_asserts i_ddsc_port_asserts (.*);

/* File: sim/ddsc_master.sv */
// Bus master model driving the two-wire or SPI pins of the command port.
// Assumes the bench resolves SDA as an open-drain line with a pull-up.
module ddsc_master
(
	input  wire logic clk_i,
	input  wire logic sda_i,   // Resolved SDA line
	output logic      scl_o,
	output logic      sda_o,   // Low pulls SDA; DIN in SPI mode
	output logic      cs_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Both lines idle high, chip select released
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		cs_n_o = 1'b1;
	end
	// Wait some clocks, then act just after the edge
	task automatic step(input int n = 4);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// START or repeated START, SCL left low
	task automatic start();
		sda_o = 1'b1;
		step();
		scl_o = 1'b1;
		step();
		sda_o = 1'b0;
		step();
		scl_o = 1'b0;
	endtask
	// STOP frees the bus; SCL goes low in the same step as SDA, so SDA never falls while SCL is high
	task automatic stop();
		step();
		scl_o = 1'b0;
		sda_o = 1'b0;
		step();
		scl_o = 1'b1;
		step();
		sda_o = 1'b1;
		step();
	endtask
	// Send n bits MSB first; a full byte gets a ninth clock for the ack
	task automatic wbyte(input logic [7:0] d, input int n, output logic ack);
		ack = 1'b1;
		for (int i = 7; i > 7 - n; i--)
		begin
			step();
			sda_o = d[i];
			step();
			scl_o = 1'b1;
			step();
			scl_o = 1'b0;
		end
		if (n == 8)
		begin
			step();
			sda_o = 1'b1;
			step();
			scl_o = 1'b1;
			step(2);
			ack = sda_i;
			step(2);
			scl_o = 1'b0;
		end
	endtask
	// SPI frame of n clocks; DIN does not keep its last bit afterwards
	task automatic spi_word(input logic [15:0] w, input int n);
		cs_n_o = 1'b0;
		for (int i = 15; i > 15 - n; i--)
		begin
			step();
			scl_o = 1'b0;
			sda_o = w[i];
			step();
			scl_o = 1'b1;
		end
		step();
		cs_n_o = 1'b1;
		sda_o = ~sda_o;
		step();
	endtask
endmodule // ddsc_master

/* File: sim/testbench.sv */
// Self-checking bench for the dual DAC serial command port.
// Assumes ddsc_master as partner; SDA pull-up modelled by a wired AND.
module testbench import ddsc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       spi_select_i = 1'b0;
	logic [1:0] strap = 2'h0;
	logic       scl, m_sda, cs_n, oe_n, ack, ref_int, en_a, en_b, er, strobe;
	wire        sda_line = m_sda & oe_n;
	ddsc_chan_s chan_a, chan_b, ea, eb;
	int         n_fail = 0;
	int         samples_checked = 0;
	int         n_strobe = 0;
	int         exp_strobe = 0;
	logic [5:0] cmds[$] = '{CMD_NOP, CMD_LD_AB, CMD_IN_A, CMD_UPD_A, CMD_IN_B, CMD_UPD_AB,
		CMD_LD_A, CMD_LD_B, CMD_IN_AB, CMD_UPD_B, CMD_REF_INT, CMD_SD_A, CMD_LD_AB, CMD_SD_B,
		CMD_REF_EXT, CMD_SD_AB, CMD_PU_A, CMD_PU_B, CMD_SD_AB, CMD_PU_AB, 6'h08};

	ddsc_master i_ddsc_master (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_o(m_sda),
		.cs_n_o(cs_n));
	ddsc_port i_ddsc_port (.clk_i(clk_i), .rst_i(rst_i), .spi_select_i(spi_select_i),
		.scl_i(scl), .sda_i(sda_line), .cs_n_i(cs_n), .addr_strap_low_i(strap[0]),
		.addr_strap_high_i(strap[1]), .sda_oe_n_o(oe_n), .sda_o(), .chan_a_o(chan_a),
		.chan_b_o(chan_b), .ref_internal_o(ref_int), .out_en_a_o(en_a), .out_en_b_o(en_b),
		.cmd_strobe_o(strobe));

	// Clock and watchdog
	initial
	begin
		forever #10 clk_i = ~clk_i;
	end
	initial
	begin
		#800_000;
		n_fail++;
		wrap_up();
	end
	// Counts executed command words, one per strobe cycle
	always @(posedge clk_i)
	begin
		if (strobe === 1'b1)
			n_strobe++;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Reference model of the command decode
	task automatic apply(input logic [5:0] c, input logic [9:0] d);
		logic a;
		logic b;
		a = c inside {CMD_LD_AB, CMD_LD_A, CMD_IN_AB, CMD_IN_A, CMD_UPD_AB, CMD_UPD_A,
			CMD_SD_AB, CMD_SD_A, CMD_PU_AB, CMD_PU_A};
		b = c inside {CMD_LD_AB, CMD_LD_B, CMD_IN_AB, CMD_IN_B, CMD_UPD_AB, CMD_UPD_B,
			CMD_SD_AB, CMD_SD_B, CMD_PU_AB, CMD_PU_B};
		if (c inside {[CMD_LD_AB:CMD_IN_B]})
			{ea.input_code, eb.input_code} = {a ? d : ea.input_code, b ? d : eb.input_code};
		if (c inside {[CMD_LD_AB:CMD_LD_B], [CMD_UPD_AB:CMD_UPD_B]})
			{ea.dac_code, eb.dac_code} = {a ? ea.input_code : ea.dac_code,
				b ? eb.input_code : eb.dac_code};
		if (c inside {[CMD_SD_AB:CMD_SD_B]})
			{ea.shutdown, eb.shutdown} = {ea.shutdown | a, eb.shutdown | b};
		if (c inside {[CMD_PU_AB:CMD_PU_B]})
			{ea.shutdown, eb.shutdown} = {ea.shutdown & !a, eb.shutdown & !b};
		if (c inside {CMD_REF_INT, CMD_REF_EXT})
			er = (c == CMD_REF_INT);
		if (c[5:3] == CMD_RNG_A && c[2:0] <= RANGE_MAX)
			ea.range = c[2:0];
		if (c[5:3] == CMD_RNG_B && c[2:0] <= RANGE_MAX)
			eb.range = c[2:0];
	endtask
	task automatic cmp_all();
		chk("chan_a", chan_a, ea);
		chk("chan_b", chan_b, eb);
		chk("ref_internal", ref_int, er);
		chk("out_en_a", en_a, !ea.shutdown);
		chk("out_en_b", en_b, !eb.shutdown);
		chk("strobes", n_strobe, exp_strobe);
	endtask
	// One write on the selected link, then model update and comparison
	task automatic send(input logic [15:0] w, input logic fin);
		if (spi_select_i)
			i_ddsc_master.spi_word(w, 16);
		else
		begin
			i_ddsc_master.start();
			i_ddsc_master.wbyte({ADDR_FIXED, strap, 1'b0}, 8, ack);
			chk("addr_ack", ack, 1'b0);
			i_ddsc_master.wbyte(w[15:8], 8, ack);
			chk("cmd_ack", ack, 1'b0);
			i_ddsc_master.wbyte(w[7:0], 8, ack);
			chk("data_ack", ack, 1'b0);
			if (fin)
				i_ddsc_master.stop();
		end
		apply(w[15:10], w[9:0]);
		exp_strobe++;
		i_ddsc_master.step();
		cmp_all();
	endtask
	// Main sequence
	initial
	begin
		void'($urandom(44468));
		{ea, eb, er} = '0;
		for (int k = 0; k < 7; k++)
			cmds.push_back(k[0] ? {CMD_RNG_B, 3'(k)} : {CMD_RNG_A, 3'(6 - k)});
		repeat (10) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		i_ddsc_master.step();
		cmp_all();
		for (int m = 0; m < 2; m++)
		begin
			spi_select_i = m[0];
			strap = 2'($urandom);
			i_ddsc_master.step();
			foreach (cmds[i])
				send({cmds[i], 10'($urandom)}, i[0] || m == 1);
			i_ddsc_master.stop();
		end
		spi_select_i = 1'b0;
		i_ddsc_master.step();
		for (int j = 0; j < 3; j++)
		begin
			i_ddsc_master.start();
			i_ddsc_master.wbyte(j == 0 ? {ADDR_FIXED, strap, 1'b1} :
				j == 1 ? {ADDR_FIXED, ~strap, 1'b0} : 8'hf0, 8, ack);
			chk("bad_addr_ack", ack, 1'b1);
			i_ddsc_master.wbyte({CMD_LD_AB, 2'h3}, 8, ack);
			chk("ignored_ack", ack, 1'b1);
			i_ddsc_master.wbyte(8'hff, 8, ack);
			i_ddsc_master.stop();
			cmp_all();
		end
		i_ddsc_master.start();
		i_ddsc_master.wbyte({ADDR_FIXED, strap, 1'b0}, 8, ack);
		i_ddsc_master.wbyte({CMD_LD_AB, 2'h2}, 8, ack);
		// Six data bits: the STOP's own SCL rise is then the 25th, short of the update point
		i_ddsc_master.wbyte(8'h5a, 6, ack);
		i_ddsc_master.stop();
		cmp_all();
		send({CMD_LD_A, 10'h3ff}, 1'b1);
		spi_select_i = 1'b1;
		i_ddsc_master.step();
		i_ddsc_master.spi_word({CMD_LD_B, 10'h155}, 15);
		cmp_all();
		rst_i = 1'b1;
		i_ddsc_master.step(2);
		rst_i = 1'b0;
		{ea, eb, er} = '0;
		i_ddsc_master.step();
		cmp_all();
		wrap_up();
	end
endmodule // testbench
